// >>> src/or_and_exec.sv
// Execution unit for no-op, AND/OR word immediate and the OR instruction family.
// Assumes main storage on ref_clk with a req/ack handshake and an error flag.
`timescale 1ns/1ps
module or_and_exec (
	// Clock, reset, enable
	input  wire logic                        ref_clk,
	input  wire logic                        rst_n,
	input  wire logic                        ce,
	// Avalon-MM slave
	input  wire logic [or_exec_pkg::AV_AW-1:0] avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [31:0]                 avs_writedata,
	input  wire logic [3:0]                  avs_byteenable,
	output logic      [31:0]                 avs_readdata,
	output logic                             avs_waitrequest,
	// Main storage
	output logic                             mem_req,
	output logic                             mem_we,
	output logic                             mem_byte,
	output logic      [15:0]                 mem_addr,
	output logic      [15:0]                 mem_wdata,
	input  wire logic                        mem_ack,
	input  wire logic                        mem_err,
	input  wire logic [15:0]                 mem_rdata
);
	import or_exec_pkg::*;

	logic [15:0] gpr [NUM_GPR];
	logic [15:0] ir;
	logic [15:0] ext1;
	logic [15:0] ext2;
	logic [15:0] ea;
	logic [31:0] opa;
	logic [31:0] opb;
	logic        opn;
	logic        wi;
	logic        ind_even;
	logic        ind_neg;
	logic        ind_zero;
	logic        carry;
	logic        ovf;
	logic        chk_isa;
	logic        chk_spec;
	logic        chk_bad;
	state_t      state;
	kind_t       kind;
	size_t       size;
	logic [31:0] status_w;

	// Decode
	wire [4:0] f_opc = ir[P_OPC +: 5];
	wire [4:0] f_fn5 = ir[P_FN5 +: 5];
	wire [2:0] f_r = ir[P_R +: 3];
	wire [2:0] f_r2 = ir[P_R2 +: 3];
	wire [2:0] f_r1p = f_r + 3'h1;

	always_comb begin
		kind = K_BAD;
		size = SZ_W;
		case (f_opc)
			OPC_BRANCH: begin
				if (ir[P_OPC-1:0] == '0)
					kind = K_NOP;
			end
			OPC_RS_BYTE: begin
				kind = K_RS;
				size = SZ_B;
			end
			OPC_RS_WORD: begin
				kind = K_RS;
			end
			OPC_RS_DWORD: begin
				kind = K_RS;
				size = SZ_D;
			end
			OPC_SS_WORD: begin
				kind = K_SS;
			end
			OPC_SS_DWORD: begin
				kind = K_SS;
				size = SZ_D;
			end
			OPC_LONG: begin
				kind = K_LONG;
			end
			OPC_RR: begin
				if (f_fn5 == FN_OR_RR)
					kind = K_RR;
			end
			OPC_IMM_REG: begin
				if (f_fn5 == FN_OWI || f_fn5 == FN_NWI)
					kind = K_RR;
			end
			OPC_IMM_STOR: begin
				// Nonzero spare bits are refused so later encodings stay free
				if (ir[P_R +: 3] == 3'h0 && ir[P_FN4 +: 4] == FN_OWI_ST)
					kind = K_IMST;
			end
			default: begin
				kind = K_BAD;
			end
		endcase
	end

	// Effective address of the current operand
	wire        is_ss = (kind == K_SS);
	wire [1:0]  am_ss0 = ir[P_AM1 +: 2];
	wire [1:0]  rb_ss = opn ? ir[P_RB2 +: 2] : ir[P_RB1 +: 2];
	wire [1:0]  am_ss = opn ? ir[P_AM2 +: 2] : am_ss0;
	wire [1:0]  f_rb = is_ss ? rb_ss : ir[P_RB +: 2];
	wire [1:0]  f_am = is_ss ? am_ss : ir[P_AM +: 2];
	wire        use_ext2 = (kind == K_IMST) || (opn && am_ss0[1]);
	wire [15:0] f_disp = use_ext2 ? ext2 : ext1;
	wire [15:0] rb_val = gpr[{1'b0, f_rb}];
	wire [15:0] am_sum = 16'(rb_val + f_disp);
	wire [15:0] am_addr = f_am[1] ? am_sum : rb_val;
	wire [15:0] r2_part = (f_r2 == 3'h0) ? 16'h0000 : gpr[f_r2];
	wire [15:0] lg_addr = 16'(ext1 + r2_part);
	wire        is_long = (kind == K_LONG);
	wire [15:0] a_base = is_long ? lg_addr : am_addr;
	wire        a_ind = is_long ? ir[P_X] : (f_am == AM_IND);
	wire        a_inc = !is_long && (f_am == AM_POST);
	wire [15:0] inc_w = (size == SZ_D) ? INC_D : INC_W;
	wire [15:0] inc_amt = (size == SZ_B) ? INC_B : inc_w;
	wire [15:0] ea_nxt = 16'(ea + INC_W);

	// Boundary checks, each made before the storage access it guards
	wire wide = (size != SZ_B);
	wire ptr_odd = a_ind && a_base[0];
	wire dir_odd = !a_ind && wide && a_base[0];
	wire ind_odd = wide && mem_rdata[0];
	wire addr_odd = ptr_odd || dir_odd;

	// Operand assembly
	wire        rd_ack = mem_req && mem_ack;
	wire        rd_last = (size != SZ_D) || wi;
	wire [31:0] rd_b = {24'h000000, mem_rdata[7:0]};
	wire [31:0] rd_w = {16'h0000, mem_rdata};
	wire [31:0] rd_d = {opb[31:16], mem_rdata};
	wire [31:0] rd_val = (size == SZ_B) ? rd_b : (size == SZ_W) ? rd_w : rd_d;

	// Result
	wire [15:0] r_val = gpr[f_r];
	wire [31:0] rs_b = {24'h000000, r_val[7:0]};
	wire [31:0] rs_w = {16'h0000, r_val};
	wire [31:0] rs_d = {r_val, gpr[f_r1p]};
	wire [31:0] rs_src = (size == SZ_B) ? rs_b : (size == SZ_W) ? rs_w : rs_d;
	wire [31:0] im_src = {16'h0000, ext1};
	wire [31:0] src = is_ss ? opa : (kind == K_IMST) ? im_src : rs_src;
	wire [31:0] res = src | opb;
	wire [15:0] rr_or = gpr[f_r] | gpr[f_r2];
	wire [15:0] im_and = ext1 & gpr[f_r];
	wire [15:0] im_or = ext1 | gpr[f_r];
	wire [15:0] im_res = (f_fn5 == FN_NWI) ? im_and : im_or;
	wire [15:0] rr_res = (f_opc == OPC_RR) ? rr_or : im_res;
	wire        to_mem = is_ss || (kind == K_IMST) || (kind == K_RS && ir[P_DEST]);
	wire [15:0] wr_hi = (size == SZ_D) ? res[31:16] : res[15:0];

	// Register file write ports
	wire        rr_go = (state == S_DEC) && (kind == K_RR);
	wire        ex_reg = (state == S_EXEC) && !to_mem;
	wire        wa_en = rr_go || ex_reg;
	wire [2:0]  wa_idx = rr_go ? f_r2 : f_r;
	wire [15:0] byte_d = {r_val[15:8], res[7:0]};
	wire [15:0] ex_d = (size == SZ_B) ? byte_d : wr_hi;
	wire [15:0] wa_d = rr_go ? rr_res : ex_d;
	wire        wb_en = ex_reg && (size == SZ_D);
	wire        inc_en = (state == S_ADDR) && a_inc;

	// Flags raised by execution
	wire ind_ok = (state == S_IND) && rd_ack && !mem_err;
	wire set_isa = rd_ack && mem_err;
	wire set_spec = ((state == S_ADDR) && addr_odd) || (ind_ok && ind_odd);
	wire set_bad = (state == S_DEC) && (kind == K_BAD);
	wire set_ind = rr_go || (state == S_EXEC);
	wire [31:0] ind_src = rr_go ? {16'h0000, rr_res} : res;
	wire ind_sgn_w = (size == SZ_D) ? ind_src[31] : ind_src[15];
	wire ind_sgn = (size == SZ_B) ? ind_src[7] : ind_sgn_w;

	// Bus decode
	wire        idle = (state == S_IDLE);
	wire        bus_acc = (avs_read || avs_write) && avs_waitrequest;
	wire        bus_wr = bus_acc && avs_write;
	wire        sel_gpr = (avs_address & GPR_MASK) == OFF_GPR;
	wire        sel_st = (avs_address == OFF_STATUS);
	wire        sel_e1 = (avs_address == OFF_EXT1);
	wire        sel_e2 = (avs_address == OFF_EXT2);
	wire        sel_cmd = (avs_address == OFF_CMD);
	wire [2:0]  bus_idx = avs_address[P_GIDX +: 3];
	wire [15:0] be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire [15:0] wd16 = avs_writedata[15:0] & be_mask;
	wire [15:0] bus_gd = (gpr[bus_idx] & ~be_mask) | wd16;
	wire [15:0] e1_d = (ext1 & ~be_mask) | wd16;
	wire [15:0] e2_d = (ext2 & ~be_mask) | wd16;
	// Operands and registers are frozen while an instruction runs
	wire        bus_gwe = bus_wr && sel_gpr && idle;
	wire        start = bus_wr && sel_cmd && idle;
	wire        st_wr = bus_wr && sel_st && avs_byteenable[0];

	always_comb begin
		status_w = 32'h00000000;
		status_w[ST_BUSY] = !idle;
		status_w[ST_EVEN] = ind_even;
		status_w[ST_NEG] = ind_neg;
		status_w[ST_ZERO] = ind_zero;
		status_w[ST_CARRY] = carry;
		status_w[ST_OVF] = ovf;
		status_w[ST_ISA] = chk_isa;
		status_w[ST_SPEC] = chk_spec;
		status_w[ST_BAD] = chk_bad;
	end

	wire [31:0] rd_g = {16'h0000, gpr[bus_idx]};
	wire [31:0] rd_e = sel_e1 ? {16'h0000, ext1} : {16'h0000, ext2};
	wire [31:0] rd_c = sel_cmd ? {16'h0000, ir} : 32'h00000000;
	wire [31:0] rd_o = (sel_e1 || sel_e2) ? rd_e : rd_c;
	wire [31:0] rd_mux = sel_gpr ? rd_g : sel_st ? status_w : rd_o;

	// Avalon answer: one wait cycle, then waitrequest low for one cycle
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
		end else if (ce) begin
			avs_waitrequest <= !bus_acc;
			if (bus_acc && avs_read)
				avs_readdata <= rd_mux;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ir <= 16'h0000;
			ext1 <= 16'h0000;
			ext2 <= 16'h0000;
		end else if (ce) begin
			if (start)
				ir <= avs_writedata[15:0];
			if (bus_wr && sel_e1 && idle)
				ext1 <= e1_d;
			if (bus_wr && sel_e2 && idle)
				ext2 <= e2_d;
		end
	end

	// Status: hardware set wins over a software clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			carry <= 1'b0;
			ovf <= 1'b0;
			chk_isa <= 1'b0;
			chk_spec <= 1'b0;
			chk_bad <= 1'b0;
			ind_even <= 1'b0;
			ind_neg <= 1'b0;
			ind_zero <= 1'b0;
		end else if (ce) begin
			if (st_wr) begin
				carry <= avs_writedata[ST_CARRY];
				ovf <= avs_writedata[ST_OVF];
				chk_isa <= chk_isa & ~avs_writedata[ST_ISA];
				chk_spec <= chk_spec & ~avs_writedata[ST_SPEC];
				chk_bad <= chk_bad & ~avs_writedata[ST_BAD];
			end
			if (set_isa)
				chk_isa <= 1'b1;
			if (set_spec)
				chk_spec <= 1'b1;
			if (set_bad)
				chk_bad <= 1'b1;
			if (set_ind) begin
				ind_even <= !ind_src[0];
				ind_neg <= ind_sgn;
				ind_zero <= (ind_src == 32'h00000000);
			end
		end
	end

	// General registers
	for (genvar i = 0; i < NUM_GPR; i++) begin : g_gpr
		always_ff @(posedge ref_clk) begin
			if (!rst_n) begin
				gpr[i] <= GPR_RST;
			end else if (ce) begin
				if (bus_gwe && bus_idx == 3'(i))
					gpr[i] <= bus_gd;
				if (inc_en && {1'b0, f_rb} == 3'(i))
					gpr[i] <= 16'(gpr[i] + inc_amt);
				if (wa_en && wa_idx == 3'(i))
					gpr[i] <= wa_d;
				if (wb_en && f_r1p == 3'(i))
					gpr[i] <= res[15:0];
			end
		end
	end

	// Sequencer; a fault returns to idle with no result written, but a post-increment base has already advanced
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state <= S_IDLE;
			opn <= 1'b0;
			wi <= 1'b0;
			ea <= 16'h0000;
			opa <= 32'h00000000;
			opb <= 32'h00000000;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_byte <= 1'b0;
			mem_addr <= 16'h0000;
			mem_wdata <= 16'h0000;
		end else if (ce) begin
			if (rd_ack)
				mem_req <= 1'b0;
			case (state)
				S_IDLE: begin
					if (start)
						state <= S_DEC;
				end
				S_DEC: begin
					opn <= 1'b0;
					wi <= 1'b0;
					opb <= 32'h00000000;
					if (kind == K_RS || is_ss || is_long || kind == K_IMST)
						state <= S_ADDR;
					else
						state <= S_IDLE;
				end
				S_ADDR: begin
					if (addr_odd) begin
						state <= S_IDLE;
					end else begin
						mem_req <= 1'b1;
						mem_we <= 1'b0;
						mem_addr <= a_base;
						mem_byte <= !a_ind && !wide;
						ea <= a_base;
						state <= a_ind ? S_IND : S_RD;
					end
				end
				S_IND: begin
					if (rd_ack) begin
						if (mem_err || ind_odd) begin
							state <= S_IDLE;
						end else begin
							mem_req <= 1'b1;
							mem_addr <= mem_rdata;
							mem_byte <= !wide;
							ea <= mem_rdata;
							state <= S_RD;
						end
					end
				end
				S_RD: begin
					if (rd_ack) begin
						if (mem_err) begin
							state <= S_IDLE;
						end else if (!rd_last) begin
							opb[31:16] <= mem_rdata;
							wi <= 1'b1;
							mem_req <= 1'b1;
							mem_addr <= ea_nxt;
						end else if (is_ss && !opn) begin
							opa <= rd_val;
							opn <= 1'b1;
							wi <= 1'b0;
							state <= S_ADDR;
						end else begin
							opb <= rd_val;
							state <= S_EXEC;
						end
					end
				end
				S_EXEC: begin
					if (to_mem) begin
						mem_req <= 1'b1;
						mem_we <= 1'b1;
						mem_byte <= !wide;
						mem_addr <= ea;
						mem_wdata <= wr_hi;
						wi <= 1'b0;
						state <= S_WR;
					end else begin
						state <= S_IDLE;
					end
				end
				S_WR: begin
					if (rd_ack) begin
						if (!mem_err && size == SZ_D && !wi) begin
							wi <= 1'b1;
							mem_req <= 1'b1;
							mem_addr <= ea_nxt;
							mem_wdata <= res[15:0];
						end else begin
							mem_we <= 1'b0;
							state <= S_IDLE;
						end
					end
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end
endmodule // or_and_exec

// >>> src/or_exec_pkg.sv
// Constants, field positions, opcodes and types for the OR/AND execution unit.
// Assumes instruction bit 0 of the printed format is ir[15] of a 16-bit word.
// Function
// - Shared no-op/branch encoding with bits 5-15 zero does nothing at all.
// - AND word immediate: immediate AND first register into second register.
// - Logical results leave carry and overflow alone; set even, negative, zero.
// - OR byte: register low byte OR storage byte, routed by bit 12.
// - OR byte into register keeps register bits 0-7, replaces low byte.
// - OR byte raises specification check only for an odd indirect address.
// - OR doubleword: register pair R,R+1 OR storage doubleword, routed by bit 12.
// - Register field 7 pairs register 7 (high) with register 0 (low).
// - OR doubleword register/storage checks odd direct and indirect addresses.
// - OR doubleword storage/storage writes result over operand 2 only.
// - Invalid address ends storage/storage; base 1 increment still happens.
// - OR word register/register ORs first into second register, no checks.
// - Register/storage forms send result to storage when bit 12 is one.
// - Long format address is field plus second register, none when zero.
// - Long format bit 11 selects direct or indirect effective address.
// - Long format writes storage word OR first register into first register.
// - OR word storage/storage writes result over operand 2 only.
// - OR word immediate ORs immediate with first register into second register.
// - Storage immediate form has no appended address word for modes 00, 01.
// - Storage immediate form fetches an appended address word for modes 10, 11.
// - Word and doubleword operands check odd indirect and operand addresses.
// - Operand outside installed storage raises invalid storage address check.
// - Storage immediate ORs immediate into storage word; bits 5-7 must be zero.
package or_exec_pkg;
	localparam int AV_AW = 6;
	localparam int NUM_GPR = 8;
	// Register map, byte offsets
	localparam logic [5:0] OFF_CMD = 6'h00;
	localparam logic [5:0] OFF_EXT1 = 6'h04;
	localparam logic [5:0] OFF_EXT2 = 6'h08;
	localparam logic [5:0] OFF_STATUS = 6'h0c;
	localparam logic [5:0] OFF_GPR = 6'h20;
	localparam logic [5:0] GPR_MASK = 6'h23;
	localparam int P_GIDX = 2;
	// Status bit positions
	localparam int ST_BUSY = 0;
	localparam int ST_EVEN = 1;
	localparam int ST_NEG = 2;
	localparam int ST_ZERO = 3;
	localparam int ST_CARRY = 4;
	localparam int ST_OVF = 5;
	localparam int ST_ISA = 6;
	localparam int ST_SPEC = 7;
	localparam int ST_BAD = 8;
	// Instruction field positions (low bit of each field)
	localparam int P_OPC = 11;
	localparam int P_R = 8;
	localparam int P_R2 = 5;
	localparam int P_RB = 6;
	localparam int P_AM = 4;
	localparam int P_DEST = 3;
	localparam int P_X = 4;
	localparam int P_FN5 = 0;
	localparam int P_FN4 = 0;
	localparam int P_RB1 = 9;
	localparam int P_RB2 = 7;
	localparam int P_AM1 = 5;
	localparam int P_AM2 = 3;
	// Opcodes and functions
	localparam logic [4:0] OPC_BRANCH = 5'h09;
	localparam logic [4:0] OPC_RS_BYTE = 5'h18;
	localparam logic [4:0] OPC_RS_WORD = 5'h19;
	localparam logic [4:0] OPC_RS_DWORD = 5'h1a;
	localparam logic [4:0] OPC_RR = 5'h0e;
	localparam logic [4:0] OPC_LONG = 5'h0d;
	localparam logic [4:0] OPC_SS_WORD = 5'h11;
	localparam logic [4:0] OPC_SS_DWORD = 5'h12;
	localparam logic [4:0] OPC_IMM_REG = 5'h0f;
	localparam logic [4:0] OPC_IMM_STOR = 5'h08;
	localparam logic [4:0] FN_OR_RR = 5'h00;
	localparam logic [4:0] FN_OWI = 5'h03;
	localparam logic [4:0] FN_NWI = 5'h0b;
	localparam logic [3:0] FN_OWI_ST = 4'hc;
	// Address modes
	localparam logic [1:0] AM_POST = 2'b01;
	localparam logic [1:0] AM_IND = 2'b11;
	// Reset values and increments
	localparam logic [15:0] GPR_RST = 16'h0000;
	localparam logic [15:0] INC_B = 16'h0001;
	localparam logic [15:0] INC_W = 16'h0002;
	localparam logic [15:0] INC_D = 16'h0004;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_DEC = 3'b001,
		S_ADDR = 3'b010,
		S_IND = 3'b011,
		S_RD = 3'b100,
		S_EXEC = 3'b101,
		S_WR = 3'b110
	} state_t;
	typedef enum logic [2:0] {
		K_BAD = 3'b000,
		K_NOP = 3'b001,
		K_RR = 3'b010,
		K_RS = 3'b011,
		K_SS = 3'b100,
		K_LONG = 3'b101,
		K_IMST = 3'b110
	} kind_t;
	typedef enum logic [1:0] {
		SZ_B = 2'b00,
		SZ_W = 2'b01,
		SZ_D = 2'b10
	} size_t;
endpackage

// >>> tb/logical_or_and_instruction_exec_test.sv
// Self-checking bench for the OR/AND execution unit over its register bus.
// Assumes storage_model on the storage port and the bound checker.
`timescale 1ns/1ps
module logical_or_and_instruction_exec_test;
	import or_exec_pkg::*;
	logic        ref_clk, rst_n, slow, note_rd, avs_read, avs_write, avs_waitrequest;
	logic [5:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd, st;
	logic        mem_req, mem_we, mem_byte, mem_ack, mem_err;
	logic [15:0] mem_addr, mem_wdata, mem_rdata, a, b, c, d, r;
	logic [31:0] seed = 32'hd31f5a7c;
	logic [31:0] notes[$];
	int          fails = 0;
	int          checks_done = 0;

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	or_and_exec dut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.mem_req(mem_req), .mem_we(mem_we), .mem_byte(mem_byte), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_err(mem_err), .mem_rdata(mem_rdata));
	storage_model store (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow), .mem_req(mem_req),
		.mem_we(mem_we), .mem_byte(mem_byte), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_ack(mem_ack), .mem_err(mem_err), .mem_rdata(mem_rdata));

	function automatic logic [15:0] rnd();
		for (int i = 0; i < 16; i++)
			seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[15:0];
	endfunction
	// Word results pass {v, v}: same zero, sign and low bit as v alone
	function automatic logic [31:0] ind(input logic [31:0] v);
		return {28'h3, v == 32'h0, v[31], !v[0], 1'b0};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [5:0] ad, input logic [31:0] wd,
		input logic nt);
		int n;
		@(posedge ref_clk);
		avs_address <= ad;
		avs_writedata <= wd;
		avs_write <= w;
		avs_read <= !w;
		note_rd <= nt;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		if (avs_waitrequest !== 1'b0) begin
			fails++;
			tally_and_finish();
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	// Results are noted here and compared by the watcher below
	task automatic rc(input logic [5:0] ad, input logic [31:0] e);
		notes.push_back(e);
		bus(1'b0, ad, 32'h0, 1'b1);
	endtask
	always @(posedge ref_clk)
		if (avs_read && note_rd && avs_waitrequest === 1'b0 && notes.size() > 0)
			check(avs_readdata, notes.pop_front());
	task automatic gw(input int n, input logic [15:0] v);
		bus(1'b1, OFF_GPR | 6'(n * 4), {16'h0, v}, 1'b0);
	endtask
	task automatic gr(input int n, input logic [15:0] v);
		rc(OFF_GPR | 6'(n * 4), {16'h0, v});
	endtask
	task automatic sr(input logic [31:0] v);
		st = ind(v);
		rc(OFF_STATUS, st);
	endtask
	task automatic mw(input logic [15:0] ad, input logic [15:0] v);
		{store.mem[ad[9:0]], store.mem[ad[9:0] + 10'd1]} = v;
	endtask
	task automatic mc(input logic [15:0] ad, input logic [15:0] e);
		check({16'h0, store.mem[ad[9:0]], store.mem[ad[9:0] + 10'd1]}, {16'h0, e});
	endtask
	// Extension words go first: the command write starts execution
	task automatic op(input logic [15:0] cmd, input logic [15:0] e1, input logic [15:0] e2);
		int n;
		slow <= rnd() > 16'h8000;
		bus(1'b1, OFF_EXT1, {16'h0, e1}, 1'b0);
		bus(1'b1, OFF_EXT2, {16'h0, e2}, 1'b0);
		bus(1'b1, OFF_CMD, {16'h0, cmd}, 1'b0);
		n = 0;
		do begin
			bus(1'b0, OFF_STATUS, 32'h0, 1'b0);
			n++;
		end while (rd[ST_BUSY] !== 1'b0 && n < 50);
		if (rd[ST_BUSY] !== 1'b0) begin
			fails++;
			tally_and_finish();
		end
	endtask

	initial begin
		rst_n = 1'b0;
		slow = 1'b0;
		note_rd = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 6'h0;
		avs_writedata = 32'h0;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		rc(OFF_STATUS, 32'h0);
		rc(OFF_GPR | 6'h1c, 32'h0);
		bus(1'b1, 6'h14, 32'hffff, 1'b0);
		rc(6'h14, 32'h0);
		bus(1'b1, OFF_STATUS, 32'h30, 1'b0);
		st = 32'h30;
		op({OPC_BRANCH, 11'h0}, 16'h0, 16'h0);
		rc(OFF_STATUS, st);
		op({OPC_BRANCH, 11'h1}, 16'h0, 16'h0);
		rc(OFF_STATUS, st | 32'h100);
		bus(1'b1, OFF_STATUS, 32'h1f0, 1'b0);
		a = rnd();
		b = rnd();
		c = rnd();
		d = rnd();
		gw(1, a);
		op({OPC_IMM_REG, 3'd1, 3'd2, FN_NWI}, b, 16'h0);
		gr(2, a & b);
		gr(1, a);
		sr({a & b, a & b});
		gw(3, a);
		op({OPC_IMM_REG, 3'd3, 3'd3, FN_OWI}, b, 16'h0);
		gr(3, a | b);
		gw(4, c);
		gw(5, b);
		op({OPC_RR, 3'd4, 3'd5, FN_OR_RR}, 16'h0, 16'h0);
		gr(5, c | b);
		gr(4, c);
		sr({c | b, c | b});
		gw(0, 16'h100);
		mw(16'h100, b);
		gw(6, a);
		op({OPC_RS_WORD, 3'd6, 2'd0, 2'b00, 1'b0, 3'd0}, 16'h0, 16'h0);
		gr(6, a | b);
		gw(6, c);
		op({OPC_RS_WORD, 3'd6, 2'd0, 2'b01, 1'b1, 3'd0}, 16'h0, 16'h0);
		mc(16'h100, c | b);
		gr(6, c);
		gr(0, 16'h102);
		gw(1, 16'h105);
		mw(16'h104, a);
		gw(7, d);
		op({OPC_RS_BYTE, 3'd7, 2'd1, 2'b00, 1'b0, 3'd0}, 16'h0, 16'h0);
		gr(7, {d[15:8], d[7:0] | a[7:0]});
		gw(2, 16'h110);
		mw(16'h110, b);
		mw(16'h112, c);
		gw(7, a);
		gw(0, d);
		op({OPC_RS_DWORD, 3'd7, 2'd2, 2'b00, 1'b0, 3'd0}, 16'h0, 16'h0);
		gr(7, a | b);
		gr(0, d | c);
		sr({a | b, d | c});
		gw(2, 16'h111);
		op({OPC_RS_DWORD, 3'd7, 2'd2, 2'b00, 1'b0, 3'd0}, 16'h0, 16'h0);
		gr(7, a | b);
		rc(OFF_STATUS, st | 32'h80);
		bus(1'b1, OFF_STATUS, 32'h1f0, 1'b0);
		gw(1, 16'h101);
		op({OPC_RS_WORD, 3'd6, 2'd1, 2'b00, 1'b1, 3'd0}, 16'h0, 16'h0);
		mc(16'h100, c | b);
		rc(OFF_STATUS, st | 32'h80);
		bus(1'b1, OFF_STATUS, 32'h1f0, 1'b0);
		// Byte operand through an odd pointer: checked even though bytes may be odd
		op({OPC_RS_BYTE, 3'd7, 2'd1, 2'b11, 1'b1, 3'd0}, 16'h0, 16'h0);
		gr(7, a | b);
		rc(OFF_STATUS, st | 32'h80);
		bus(1'b1, OFF_STATUS, 32'h1f0, 1'b0);
		gw(3, a);
		mw(16'h120, 16'h130);
		op({OPC_LONG, 3'd3, 3'd0, 1'b0, 4'h0}, 16'h120, 16'h0);
		r = a | 16'h130;
		gr(3, r);
		gw(1, 16'h20);
		mw(16'h130, b);
		op({OPC_LONG, 3'd3, 3'd1, 1'b1, 4'h0}, 16'h100, 16'h0);
		gr(3, r | b);
		gw(0, 16'h140);
		gw(1, 16'h144);
		mw(16'h140, a);
		mw(16'h142, b);
		mw(16'h144, c);
		mw(16'h146, d);
		op({OPC_SS_WORD, 2'd0, 2'd1, 2'b00, 2'b00, 3'd0}, 16'h0, 16'h0);
		mc(16'h144, a | c);
		mc(16'h140, a);
		op({OPC_SS_DWORD, 2'd0, 2'd1, 2'b00, 2'b00, 3'd0}, 16'h0, 16'h0);
		mc(16'h146, b | d);
		mc(16'h142, b);
		sr({a | c, b | d});
		gw(1, 16'h0800);
		op({OPC_SS_WORD, 2'd0, 2'd1, 2'b01, 2'b00, 3'd0}, 16'h0, 16'h0);
		gr(0, 16'h142);
		rc(OFF_STATUS, st | 32'h40);
		bus(1'b1, OFF_STATUS, 32'h1f0, 1'b0);
		gw(3, 16'h150);
		mw(16'h150, a);
		mw(16'h154, c);
		op({OPC_IMM_STOR, 3'd0, 2'd3, 2'b00, FN_OWI_ST}, b, 16'h0);
		mc(16'h150, a | b);
		op({OPC_IMM_STOR, 3'd0, 2'd3, 2'b10, FN_OWI_ST}, d, 16'h4);
		mc(16'h154, c | d);
		sr({c | d, c | d});
		// Let the watcher take the last read before the verdict
		@(posedge ref_clk);
		if (notes.size() != 0) fails++;
		tally_and_finish();
	end
endmodule // logical_or_and_instruction_exec_test

// >>> tb/or_and_exec_props.sv
// Checker for the OR/AND execution unit: bus answers and storage handshake.
// Sees only the top-level ports; bound into every instance of the unit.
`timescale 1ns/1ps
module or_and_exec_props (
	// Clock, reset, enable
	input wire logic                          ref_clk,
	input wire logic                          rst_n,
	input wire logic                          ce,
	// Register bus
	input wire logic [or_exec_pkg::AV_AW-1:0] avs_address,
	input wire logic                          avs_read,
	input wire logic                          avs_write,
	input wire logic [31:0]                   avs_writedata,
	input wire logic [31:0]                   avs_readdata,
	input wire logic                          avs_waitrequest,
	// Storage port
	input wire logic                          mem_req,
	input wire logic                          mem_we,
	input wire logic                          mem_byte,
	input wire logic [15:0]                   mem_addr,
	input wire logic [15:0]                   mem_wdata,
	input wire logic                          mem_ack,
	input wire logic                          mem_err
);
	import or_exec_pkg::*;
	// A low enable freezes the unit, so nothing is judged while it is low
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n || !ce);
	chk_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered after one wait cycle");
	chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	chk_wait_idle: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest dropped with no request");
	chk_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0)
		else $error("read data upper half not zero");
	chk_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
		&& $stable(mem_we) && $stable(mem_wdata) && $stable(mem_byte))
		else $error("storage request changed before acknowledge");
	chk_req_drop: assert property ($fell(mem_req) |-> $past(mem_ack))
		else $error("storage request withdrawn without acknowledge");
	chk_word_even: assert property (mem_req && !mem_byte |-> !mem_addr[0])
		else $error("word storage access at odd address");
	chk_err_stop: assert property (mem_req && mem_ack && mem_err |=> !mem_req [*2])
		else $error("storage access continued after invalid address");
	chk_nop_quiet: assert property (avs_write && avs_waitrequest && avs_address == OFF_CMD
		&& avs_writedata[15:0] == {OPC_BRANCH, 11'h0} && !mem_req |=> !mem_req [*8])
		else $error("no-operation touched storage");
endmodule // or_and_exec_props

bind or_and_exec or_and_exec_props chk (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .mem_req(mem_req), .mem_we(mem_we),
	.mem_byte(mem_byte), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
	.mem_err(mem_err));

// >>> tb/storage_model.sv
// Behavioural main storage on the unit's request/acknowledge port.
// Assumes the shared ref_clk; words are big-endian, high byte at the even address.
`timescale 1ns/1ps
module storage_model #(
	parameter logic [15:0] LIMIT = 16'h0400
) (
	// Clock, reset, pacing
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        slow,
	// Storage port
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic        mem_byte,
	input  wire logic [15:0] mem_addr,
	input  wire logic [15:0] mem_wdata,
	output logic             mem_ack,
	output logic             mem_err,
	output logic      [15:0] mem_rdata
);
	logic [7:0] mem [0:1023];
	logic [1:0] wait_cnt;
	logic [9:0] ix;
	logic       bad;
	assign ix  = mem_addr[9:0];
	assign bad = mem_addr >= LIMIT;
	// Plain always: the bench preloads the array through a back door
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			mem_ack   <= 1'b0;
			mem_err   <= 1'b0;
			mem_rdata <= 16'h0;
			wait_cnt  <= 2'd0;
		end else begin
			mem_ack   <= 1'b0;
			mem_err   <= 1'b0;
			// Stale data flips every cycle so the unit cannot lean on it
			mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_ack && wait_cnt < {slow, 1'b0}) begin
				wait_cnt <= wait_cnt + 2'd1;
			end else if (mem_req && !mem_ack) begin
				wait_cnt  <= 2'd0;
				mem_ack   <= 1'b1;
				mem_err   <= bad;
				mem_rdata <= mem_byte ? {8'h0, mem[ix]} : {mem[ix], mem[ix + 10'd1]};
				if (mem_we && !bad && mem_byte)
					mem[ix] <= mem_wdata[7:0];
				if (mem_we && !bad && !mem_byte)
					{mem[ix], mem[ix + 10'd1]} <= mem_wdata;
			end
		end
	end
endmodule // storage_model
